// ===== serial_latch_load_map.svh
// constants for the serial latch load port: widths, fields, addresses, timing
`ifndef SERIAL_LATCH_LOAD_MAP_SVH
`define SERIAL_LATCH_LOAD_MAP_SVH

`define WORD_W 24
`define FIFO_DEPTH 4
`define ADDR_W 2
`define ADDR_REF 2'h0
`define ADDR_FB 2'h1
`define ADDR_FUNC 2'h2
`define ADDR_INIT 2'h3
`define MUX_LSB 4
`define MUX_W 3
`define MUX_ZERO 3'h0
`define MUX_LOCK 3'h1
`define MUX_CNT_RST 3'h2
`define MUX_PWR_DN 3'h3
`define LATCH_RESET 24'h00_0000
`define SYS_CLK_MHZ 25
`define RST_PULSE_NS 160
`define RST_PULSE_CYC ((`RST_PULSE_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ===== serial_latch_load_pkg.sv
// types shared by the serial latch load port
`default_nettype none
package serial_latch_load_pkg;
  // drain side sequencing, one-hot
  typedef enum logic [1:0] {
    DRAIN_IDLE = 2'b01,
    DRAIN_PULSE = 2'b10
  } drain_state_type;
endpackage
`default_nettype wire

// ===== latch_word_fifo.sv
// small word fifo between the serial capture and the latch writer
`default_nettype none
module latch_word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // offered word
  output logic out_valid, // word waiting
  input wire logic out_ready, // drain takes word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // word storage
  logic [AW:0] wr_q; // write pointer, extra wrap bit
  logic [AW:0] rd_q; // read pointer, extra wrap bit
  wire full_w = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty_w = (wr_q == rd_q);
  wire push_w = in_valid && in_ready;
  wire pop_w = out_valid && out_ready;

  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // storage needs no reset; it is only read behind the pointers
  always_ff @(posedge sys_clk) begin
    if (push_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push_w) wr_q <= wr_q + 1'b1;
      if (pop_w) rd_q <= rd_q + 1'b1;
    end
  end

  // occupancy never passes the depth, so the full flag stops pushes in time
  fifo_honest_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_q - rd_q) <= (AW+1)'(DEPTH))
    else $error("fifo holds more words than its depth");
endmodule // latch_word_fifo
`default_nettype wire

// ===== serial_latch_load_port.sv
// three-wire serial latch load port: capture, buffering, latch routing, monitor
`include "serial_latch_load_map.svh"
`default_nettype none

// Contract
// [R1] shift data on each serial clock rise, 24 bits
// [R2] load strobe rise copies word to latch
// [R3] host keeps serial clock at most 20 MHz
// [R4] host frames three bytes under low strobe
// [R5] host does four setup writes after power-up
// [R6] monitor pin shows selected signal, lock included
// [R7] power gate input drives power-down state
// [R8] two low bits pick destination latch
// [R9] shift register keeps working in power-down
// [R10] init load resets counters, first fb repeats
module serial_latch_load_port
  import serial_latch_load_pkg::*;
(
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic serial_clk, // serial clock pin from host
  input wire logic serial_data, // serial data pin from host
  input wire logic load_strobe, // load strobe pin from host
  input wire logic power_gate, // high runs, low powers down
  input wire logic lock_indicator, // lock detect from the loop
  output logic monitor_output_pin, // selected internal signal
  output logic load_ready, // fifo has room for a strobed word
  output logic [`WORD_W-1:0] ref_latch_q, // reference counter latch
  output logic [`WORD_W-1:0] fb_latch_q, // feedback counter latch
  output logic [`WORD_W-1:0] func_latch_q, // function latch
  output logic [`WORD_W-1:0] init_latch_q, // initialization latch
  output logic counter_reset, // internal counter reset pulse
  output logic power_down // device in power-down
);
  localparam int PULSE_CYC = `RST_PULSE_CYC;
  localparam logic [2:0] PULSE_LAST = 3'(PULSE_CYC - 1);

  // two flop synchronisers, third stage only for edge finding
  logic [2:0] sclk_q; // serial clock sync chain
  logic [1:0] sdat_q; // serial data sync chain
  logic [2:0] le_q; // load strobe sync chain
  logic [1:0] gate_q; // power gate sync chain
  logic [1:0] lock_q; // lock indicator sync chain
  logic [`WORD_W-1:0] shift_q; // input shift register
  logic arm_q; // first fb load after init still pending
  logic [2:0] pulse_cnt_q; // cycles left in reset pulse
  drain_state_type state_q; // drain sequencer
  drain_state_type state_d; // next drain state
  logic pd_q; // registered power-down
  logic mon_q; // registered monitor output

  // fifo wiring
  logic fifo_out_valid; // a word is waiting
  logic [`WORD_W-1:0] fifo_out_data; // waiting word

  function automatic logic addr_is(input logic [`WORD_W-1:0] w, input logic [1:0] a);
    return w[`ADDR_W-1:0] == a;
  endfunction

  // edges of the sampled pins
  wire sclk_rise = sclk_q[1] && !sclk_q[2];
  wire le_rise = le_q[1] && !le_q[2];
  // drain stalls during the reset pulse so fifo back-pressure is real
  wire drain_ready = (state_q == DRAIN_IDLE);
  wire pop = fifo_out_valid && drain_ready;
  wire pop_ref = pop && addr_is(fifo_out_data, `ADDR_REF); // [R8]
  wire pop_fb = pop && addr_is(fifo_out_data, `ADDR_FB); // [R8]
  wire pop_func = pop && addr_is(fifo_out_data, `ADDR_FUNC); // [R8]
  wire pop_init = pop && addr_is(fifo_out_data, `ADDR_INIT); // [R8]
  wire start_pulse = pop_init || (pop_fb && arm_q); // [R10]
  wire [`MUX_W-1:0] mux_sel = func_latch_q[`MUX_LSB +: `MUX_W];
  // monitor source select; unknown codes show a quiet low
  wire mon_d = (mux_sel == `MUX_LOCK) ? lock_q[1] : // [R6]
               (mux_sel == `MUX_CNT_RST) ? counter_reset :
               (mux_sel == `MUX_PWR_DN) ? pd_q : 1'b0;

  assign counter_reset = (state_q == DRAIN_PULSE);
  assign power_down = pd_q;
  assign monitor_output_pin = mon_q;

  // synchronisers for every pin from the host or the loop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= '0;
      sdat_q <= '0;
      le_q <= 3'h7; // idle high, so release of reset shows no false strobe rise
      gate_q <= '0;
      lock_q <= '0;
    end else begin
      sclk_q <= {sclk_q[1:0], serial_clk};
      sdat_q <= {sdat_q[0], serial_data};
      le_q <= {le_q[1:0], load_strobe};
      gate_q <= {gate_q[0], power_gate};
      lock_q <= {lock_q[0], lock_indicator};
    end
  end

  // shift register runs regardless of power-down
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_q <= `LATCH_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[`WORD_W-2:0], sdat_q[1]}; // [R1] [R9]
    end
  end

  // strobed words queue here; a strobe with no room is dropped
  latch_word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(le_rise), // [R2]
    .in_ready(load_ready),
    .in_data(shift_q),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out_data)
  );

  // latch writes; init also carries the function settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_latch_q <= `LATCH_RESET;
      fb_latch_q <= `LATCH_RESET;
      func_latch_q <= `LATCH_RESET;
      init_latch_q <= `LATCH_RESET;
    end else begin
      if (pop_ref) ref_latch_q <= fifo_out_data; // [R2]
      if (pop_fb) fb_latch_q <= fifo_out_data;
      if (pop_func || pop_init) func_latch_q <= fifo_out_data; // [R10]
      if (pop_init) init_latch_q <= fifo_out_data;
    end
  end

  // arm after init, disarm on the first fb load
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arm_q <= 1'b0;
    end else if (pop_init) begin
      arm_q <= 1'b1; // [R10]
    end else if (pop_fb) begin
      arm_q <= 1'b0; // [R10]
    end
  end

  // next state of the drain sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DRAIN_IDLE: begin
        if (start_pulse) state_d = DRAIN_PULSE;
      end
      DRAIN_PULSE: begin
        if (pulse_cnt_q == 3'h0) state_d = DRAIN_IDLE;
      end
      default: begin
        state_d = DRAIN_IDLE;
      end
    endcase
  end

  // sequencer, pulse length counter, power-down and monitor flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= DRAIN_IDLE;
      pulse_cnt_q <= 3'h0;
      pd_q <= 1'b1;
      mon_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_cnt_q <= start_pulse ? PULSE_LAST : (pulse_cnt_q - {2'h0, counter_reset});
      pd_q <= !gate_q[1]; // [R7]
      mon_q <= mon_d;
    end
  end

  // checks
  shift_capture_a: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    sclk_rise |=> shift_q == {$past(shift_q[`WORD_W-2:0]), $past(sdat_q[1])})
    else $error("serial bit not shifted in");
  strobe_latch_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    le_rise && load_ready && !fifo_out_valid && drain_ready && shift_q[1:0] == `ADDR_REF
    |=> ##1 ref_latch_q == $past(shift_q, 2))
    else $error("strobed word not latched");
  latch_route_a: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    pop_fb |=> fb_latch_q == $past(fifo_out_data) && $stable(ref_latch_q))
    else $error("word routed to wrong latch");
  monitor_lock_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    mux_sel == `MUX_LOCK && $stable(mux_sel) |=> monitor_output_pin == $past(lock_q[1]))
    else $error("monitor pin not showing lock");
  power_follow_a: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    !gate_q[1] |=> power_down)
    else $error("power gate not honoured");
  shift_pd_a: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    power_down && sclk_rise |=> shift_q[0] == $past(sdat_q[1]))
    else $error("shift stopped in power-down");
  init_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    pop_init |=> counter_reset[*4] ##1 !counter_reset)
    else $error("init reset pulse wrong length");
  fb_once_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    pop_fb && !arm_q |=> !counter_reset)
    else $error("later fb load pulsed reset");
  init_cov: cover property (@(posedge sys_clk) disable iff (rst) pop_init);
  fb_pulse_cov: cover property (@(posedge sys_clk) disable iff (rst) pop_fb && arm_q);
  fifo_full_cov: cover property (@(posedge sys_clk) disable iff (rst) !load_ready);
  mon_pulse_cov: cover property (@(posedge sys_clk) disable iff (rst)
    mux_sel == `MUX_CNT_RST && counter_reset);
endmodule // serial_latch_load_port
`default_nettype wire

// ===== serial_host_model.sv
// host side model: frames words onto the three-wire serial link
`default_nettype none
module serial_host_model (
  input wire logic sys_clk, // bench clock, pins move on its rise
  output logic serial_clk, // serial clock, still outside frames
  output logic serial_data, // serial data, msb first
  output logic load_strobe // load strobe, low while framing
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b1;
  end
  // one whole word: strobe low, three bytes msb first, strobe high
  task automatic send_word(input logic [23:0] w);
    @(posedge sys_clk) load_strobe <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // data moves as the clock falls; 8 cycles a bit gives 320 ns, under 20 MHz
      serial_data <= w[i];
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    load_strobe <= 1'b1;
    serial_data <= ~w[0]; // released line shows no stale bit
  endtask
endmodule // serial_host_model
`default_nettype wire

// ===== serial_latch_load_port_tb.sv
// self-checking bench for the serial latch load port
`default_nettype none
module serial_latch_load_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, power_gate, lock_indicator, monitor_output_pin, load_ready;
  logic counter_reset, power_down, serial_clk, serial_data, load_strobe, cr_prev;
  logic [23:0] ref_latch_q, fb_latch_q, func_latch_q, init_latch_q;
  int n_fail, samples_checked, pulses, pulse_cycles, cycles, mon_cycles;
  serial_host_model i_host (.sys_clk(sys_clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe));
  serial_latch_load_port i_dut (.sys_clk(sys_clk), .rst(rst), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe), .power_gate(power_gate),
    .lock_indicator(lock_indicator), .monitor_output_pin(monitor_output_pin),
    .load_ready(load_ready), .ref_latch_q(ref_latch_q), .fb_latch_q(fb_latch_q),
    .func_latch_q(func_latch_q), .init_latch_q(init_latch_q),
    .counter_reset(counter_reset), .power_down(power_down));
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // counts reset pulses and their width; also cuts a hang short
  always @(posedge sys_clk) begin
    cr_prev <= counter_reset;
    if (counter_reset === 1'b1 && cr_prev !== 1'b1) pulses++;
    if (counter_reset === 1'b1) pulse_cycles++;
    if (monitor_output_pin === 1'b1) mon_cycles++;
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  // word plus settle time for sync, fifo and drain
  task automatic load(input logic [23:0] w);
    i_host.send_word(w);
    repeat (12) @(posedge sys_clk);
    check("ready", 24'h00_0001, 24'(load_ready));
  endtask
  // init load: both init and function latch, one 4-cycle pulse
  task automatic test_init;
    load(24'h12_3403);
    check("init", 24'h12_3403, init_latch_q);
    check("func", 24'h12_3403, func_latch_q);
    check("pulses", 24'h00_0001, 24'(pulses));
    check("width", 24'h00_0004, 24'(pulse_cycles));
    $display("test_init done");
  endtask
  // rest of setup writes; only the first feedback load pulses again
  task automatic test_setup;
    load(24'hab_cd12);
    check("func", 24'hab_cd12, func_latch_q);
    load(24'h5a_a5a4);
    check("ref", 24'h5a_a5a4, ref_latch_q);
    load(24'h3c_3c3d);
    check("fb", 24'h3c_3c3d, fb_latch_q);
    check("pulses", 24'h00_0002, 24'(pulses));
    load(24'h00_1235);
    check("fb2", 24'h00_1235, fb_latch_q);
    check("pulses", 24'h00_0002, 24'(pulses));
    check("init", 24'h12_3403, init_latch_q);
    $display("test_setup done");
  endtask
  // monitor selects lock, then power-down state
  task automatic test_monitor;
    lock_indicator <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("mon_lock", 24'h00_0001, 24'(monitor_output_pin));
    lock_indicator <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("mon_lock", 24'h00_0000, 24'(monitor_output_pin));
    load(24'hab_cd32);
    power_gate <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("pdn", 24'h00_0001, 24'(power_down));
    check("mon_pdn", 24'h00_0001, 24'(monitor_output_pin));
    $display("test_monitor done");
  endtask
  // shifting and latching still work while powered down
  task automatic test_power;
    load(24'h01_0200);
    check("ref_pdn", 24'h01_0200, ref_latch_q);
    power_gate <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("pup", 24'h00_0000, 24'(power_down));
    check("mon_pup", 24'h00_0000, 24'(monitor_output_pin));
    $display("test_power done");
  endtask
  // a second init pulses again, so does the next feedback load; monitor shows each pulse
  task automatic test_reinit;
    mon_cycles = 0;
    load(24'h00_0023);
    check("init2", 24'h00_0023, init_latch_q);
    check("mon_rst", 24'h00_0004, 24'(mon_cycles));
    check("pulses", 24'h00_0003, 24'(pulses));
    load(24'h00_0011);
    check("fb3", 24'h00_0011, fb_latch_q);
    check("pulses", 24'h00_0004, 24'(pulses));
    check("mon_rst", 24'h00_0008, 24'(mon_cycles));
    $display("test_reinit done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios in order
  initial begin
    rst = 1'b1;
    power_gate = 1'b1;
    lock_indicator = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    pulses = 0;
    pulse_cycles = 0;
    cycles = 0;
    mon_cycles = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    test_init();
    test_setup();
    test_monitor();
    test_power();
    test_reinit();
    report_and_stop();
  end
endmodule // serial_latch_load_port_tb
`default_nettype wire
